// ### logic/gpo_pkg.sv
// Shared constants for the general output signal selector
package gpo_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] CFG0_OFS   = 8'h00;
    localparam logic [7:0] CFG1_OFS   = 8'h04;
    localparam logic [7:0] CFG2_OFS   = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;
    // Config word fields
    localparam int CODE_LSB = 0;
    localparam int CODE_W   = 6;
    localparam int INV_BIT  = 6;
    // Status word fields
    localparam int ST_LVL_LSB = 0;
    localparam int ST_OE_LSB  = 3;
    localparam int ST_GNT_LSB = 8;
    // Select codes
    localparam logic [5:0] SEL_TEST_LO   = 6'h1e;
    localparam logic [5:0] SEL_TEST_HI   = 6'h23;
    localparam logic [5:0] SEL_WAKE_A    = 6'h24;
    localparam logic [5:0] SEL_WAKE_B    = 6'h25;
    localparam logic [5:0] SEL_TEST_26   = 6'h26;
    localparam logic [5:0] SEL_SLOW_CLK  = 6'h27;
    localparam logic [5:0] SEL_TEST_28   = 6'h28;
    localparam logic [5:0] SEL_RDY_LOW   = 6'h29;
    localparam logic [5:0] SEL_TEST_2A   = 6'h2a;
    localparam logic [5:0] SEL_XTAL_OK   = 6'h2b;
    localparam logic [5:0] SEL_TEST_2C   = 6'h2c;
    localparam logic [5:0] SEL_TURN_LOW  = 6'h2d;
    localparam logic [5:0] SEL_HIGH_Z    = 6'h2e;
    localparam logic [5:0] SEL_CONST     = 6'h2f;
    localparam logic [5:0] SEL_DIV_BASE  = 6'h30;
    localparam logic [5:0] SEL_DIV_192   = 6'h3f;
    // Values after reset
    localparam logic [5:0] CFG0_RST_CODE = SEL_DIV_192;
    localparam logic [5:0] CFGX_RST_CODE = SEL_HIGH_Z;
    // Divider pattern period in ref clock cycles, twice the ratio, by code 0x30..0x3f
    localparam int PER_W = 9;
    localparam logic [8:0] DIV_PERIOD [16] = '{
        9'h002, 9'h003, 9'h004, 9'h006, 9'h008, 9'h00c, 9'h010, 9'h018,
        9'h020, 9'h030, 9'h040, 9'h060, 9'h080, 9'h0c0, 9'h100, 9'h180
    };
endpackage

// ### logic/div_if.sv
// Link between the selector and the shared crystal clock divider
`timescale 1ns/1ps
interface div_if;
    logic [8:0] period;
    logic       run;
    logic       level;
    modport ctl (output period, output run, input level);
    modport div (input period, input run, output level);
endinterface

// ### logic/xtal_divider.sv
// Shared crystal clock divider, one instance serves every pin
`timescale 1ns/1ps
module xtal_divider
    import gpo_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    // Divider link
    div_if.div        d
);
    logic [PER_W-1:0] cnt_r;
    logic [PER_W-1:0] per_r;
    logic             level_r;

    assign d.level = level_r;

    // Restart the pattern whenever the period changes, so no runt period mixes ratios
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i || !d.run || per_r != d.period) begin
            cnt_r <= '0;
        end else if (cnt_r == d.period - 9'h001) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 9'h001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            per_r <= '0;
        end else begin
            per_r <= d.period;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            level_r <= 1'b0;
        end else begin
            level_r <= d.run && (cnt_r < (d.period >> 1));
        end
    end

    a_div_wrap: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (d.run && $stable(d.period) && per_r == d.period && cnt_r == d.period - 9'h001)
        |=> cnt_r == 9'h000)
        else $error("divider did not wrap at its period");
endmodule

// ### logic/general_output_signal_select.sv
// Signal selector for the three general output pins with a Wishbone register slave
//
// How it works
// - Codes 0x1e to 0x23 are test codes; pin drives its inactive constant.
// - Single test codes 0x26, 0x28, 0x2a, 0x2c likewise drive the inactive constant.
// - Code 0x2d shows the pin 0 turnaround flag, low while pin 0 is input.
// - Code 0x2e releases the pin; 0x2f drives low, or high when inverted.
// - Three pins, each with its own select code and invert setting.
// - One shared divider; only the lowest pin selecting it gets the clock.
// - After reset pin 0 selects the crystal clock divided by 192.
//
// Implementation choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module general_output_signal_select
    import gpo_pkg::*;
#(
    parameter int PINS = 3
)(
    // Clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            rstn_i,
    // Wishbone slave
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [7:0]      wb_adr_i,
    input  wire logic [31:0]     wb_dat_i,
    input  wire logic [3:0]      wb_sel_i,
    output var  logic [31:0]     wb_dat_o,
    output var  logic            wb_ack_o,
    // Internal status sources
    input  wire logic            wake_poll_event_a_i,
    input  wire logic            wake_poll_event_b_i,
    input  wire logic            slow_osc_clock_i,
    input  wire logic            device_ready_low_i,
    input  wire logic            crystal_settled_flag_i,
    input  wire logic            pin0_input_turnaround_low_i,
    // General output pins
    output var  logic [PINS-1:0] general_output_pin_o,
    output var  logic [PINS-1:0] general_output_pin_oe_o
);
    logic [CODE_W-1:0] sel_r [PINS];
    logic [PINS-1:0]   inv_r;
    logic [PINS-1:0]   pin_nxt;
    logic [PINS-1:0]   oe_nxt;
    logic [PINS-1:0]   grant;
    logic [PINS-1:0]   grant_r;
    logic              wb_req;
    logic [31:0]       rd_nxt;

    div_if dv ();

    xtal_divider u_div (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .d         (dv.div)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register access

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // Each pin owns one config word, written without touching the others
    generate
        for (genvar k = 0; k < PINS; k++) begin : g_cfg
            always_ff @(posedge ref_clk_i) begin
                if (!rstn_i) begin
                    sel_r[k] <= (k == 0) ? CFG0_RST_CODE : CFGX_RST_CODE;
                    inv_r[k] <= 1'b0;
                end else if (wb_req && wb_we_i && wb_sel_i[0] &&
                             wb_adr_i == CFG0_OFS + 8'(4 * k)) begin
                    sel_r[k] <= wb_dat_i[CODE_LSB +: CODE_W];
                    inv_r[k] <= wb_dat_i[INV_BIT];
                end
            end
        end
    endgenerate

    always_comb begin
        rd_nxt = '0;
        if (wb_adr_i == STATUS_OFS) begin
            rd_nxt[ST_LVL_LSB +: PINS] = general_output_pin_o;
            rd_nxt[ST_OE_LSB +: PINS]  = general_output_pin_oe_o;
            rd_nxt[ST_GNT_LSB +: PINS] = grant_r;
        end else begin
            for (int i = 0; i < PINS; i++) begin
                if (wb_adr_i == CFG0_OFS + 8'(4 * i)) begin
                    rd_nxt[CODE_LSB +: CODE_W] = sel_r[i];
                    rd_nxt[INV_BIT]            = inv_r[i];
                end
            end
        end
    end

    // Unmapped addresses answer with zero data
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            wb_dat_o <= '0;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= rd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared divider arbitration

    always_comb begin
        logic taken;
        taken = 1'b0;
        grant = '0;
        for (int i = 0; i < PINS; i++) begin
            if (sel_r[i] >= SEL_DIV_BASE && !taken) begin
                grant[i] = 1'b1;
                taken    = 1'b1;
            end
        end
    end

    always_comb begin
        dv.run    = |grant;
        dv.period = DIV_PERIOD[0];
        for (int i = 0; i < PINS; i++) begin
            if (grant[i]) begin
                dv.period = DIV_PERIOD[sel_r[i][3:0]];
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            grant_r <= '0;
        end else begin
            grant_r <= grant;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per pin selection

    generate
        for (genvar k = 0; k < PINS; k++) begin : g_pin
            logic raw;
            always_comb begin
                raw       = 1'b0;
                oe_nxt[k] = 1'b1;
                case (sel_r[k])
                    SEL_WAKE_A:   raw = wake_poll_event_a_i;
                    SEL_WAKE_B:   raw = wake_poll_event_b_i;
                    SEL_SLOW_CLK: raw = slow_osc_clock_i;
                    SEL_RDY_LOW:  raw = device_ready_low_i;
                    SEL_XTAL_OK:  raw = crystal_settled_flag_i;
                    SEL_TURN_LOW: raw = pin0_input_turnaround_low_i;
                    SEL_HIGH_Z:   oe_nxt[k] = 1'b0;
                    SEL_CONST:    raw = 1'b0;
                    SEL_TEST_26, SEL_TEST_28, SEL_TEST_2A, SEL_TEST_2C:
                        raw = 1'b0;
                    default: begin
                        // Test range and lower codes stay at the inactive constant
                        raw = (sel_r[k] >= SEL_DIV_BASE) ? (grant[k] && dv.level) : 1'b0;
                    end
                endcase
                // Pin 0 becomes an input while serial transmit data is fed in
                if (k == 0 && !pin0_input_turnaround_low_i) begin
                    oe_nxt[k] = 1'b0;
                end
                pin_nxt[k] = raw ^ inv_r[k];
            end

            always_ff @(posedge ref_clk_i) begin
                if (!rstn_i) begin
                    general_output_pin_o[k]    <= 1'b0;
                    general_output_pin_oe_o[k] <= 1'b0;
                end else begin
                    general_output_pin_o[k]    <= pin_nxt[k];
                    general_output_pin_oe_o[k] <= oe_nxt[k];
                end
            end

            ////////////////////////////////////////////////////////////////////////
            // Checks

            sequence s_test_code;
                (sel_r[k] >= SEL_TEST_LO && sel_r[k] <= SEL_TEST_HI);
            endsequence

            sequence s_single_test;
                (sel_r[k] == SEL_TEST_26 || sel_r[k] == SEL_TEST_28 ||
                 sel_r[k] == SEL_TEST_2A || sel_r[k] == SEL_TEST_2C);
            endsequence

            a_test_range: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
                s_test_code |=> general_output_pin_o[k] == $past(inv_r[k]))
                else $error("test code range drove an active level");

            a_single_test: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
                s_single_test |=> general_output_pin_o[k] == $past(inv_r[k]))
                else $error("single test code drove an active level");

            a_turn_flag: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
                sel_r[k] == SEL_TURN_LOW |=>
                general_output_pin_o[k] == ($past(pin0_input_turnaround_low_i) ^ $past(inv_r[k])))
                else $error("turnaround flag not shown on pin");

            a_high_z: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
                sel_r[k] == SEL_HIGH_Z |=> !general_output_pin_oe_o[k])
                else $error("three-state code still drives the pin");

            a_const_level: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
                (sel_r[k] == SEL_CONST && (k != 0 || pin0_input_turnaround_low_i)) |=>
                general_output_pin_oe_o[k] && general_output_pin_o[k] == $past(inv_r[k]))
                else $error("constant code level wrong");

            a_wake_route: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
                sel_r[k] == SEL_WAKE_A |=>
                general_output_pin_o[k] == ($past(wake_poll_event_a_i) ^ $past(inv_r[k])))
                else $error("wake event a not routed");

            a_ready_route: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
                sel_r[k] == SEL_RDY_LOW |=>
                general_output_pin_o[k] == ($past(device_ready_low_i) ^ $past(inv_r[k])))
                else $error("ready flag not routed");

            a_lost_divider: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
                (sel_r[k] >= SEL_DIV_BASE && !grant[k]) |=>
                general_output_pin_o[k] == $past(inv_r[k]))
                else $error("pin without the divider grant drove a clock");
        end
    endgenerate

    a_one_divider: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $onehot0(grant_r) && (grant_r == '0 || grant_r == $past(grant)))
        else $error("divider granted to more than one pin");

    a_other_pins: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (wb_req && wb_we_i && wb_adr_i == CFG0_OFS) |=> $stable(sel_r[1]) && $stable(sel_r[2]))
        else $error("write to pin 0 config changed another pin");

    a_reset_div: assert property (@(posedge ref_clk_i)
        $rose(rstn_i) |-> sel_r[0] == SEL_DIV_192 ##1 grant_r[0])
        else $error("pin 0 not on divide by 192 after reset");
endmodule

// ### tb/pin_sink.sv
// Far-side reader that resolves the level seen on each general output wire
`timescale 1ns/1ps
module pin_sink #(
    parameter int PINS = 3
)(
    // Clock
    input  wire logic            ref_clk_i,
    // Pins as driven by the selector
    input  wire logic [PINS-1:0] pin_i,
    input  wire logic [PINS-1:0] oe_i,
    // Resolved wire levels
    output var  logic [PINS-1:0] wire_o
);
    logic [PINS-1:0] last_r = '0;
    always_ff @(posedge ref_clk_i) begin
        for (int i = 0; i < PINS; i++) begin
            if (oe_i[i]) begin
                last_r[i] <= pin_i[i];
            end
        end
    end
    // No pull on the wire: a released pin shows the inverse of its last level
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            wire_o[i] = oe_i[i] ? pin_i[i] : ~last_r[i];
        end
    end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the general output signal selector
`timescale 1ns/1ps
module testbench;
    import gpo_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        rstn_i    = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, rd;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [4:0]  src = 5'h00;
    logic        turn_low = 1'b1;
    logic [2:0]  pin, oe, seen;
    int          err_count = 0, check_count = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    general_output_signal_select #(.PINS(3)) uut (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wake_poll_event_a_i(src[0]), .wake_poll_event_b_i(src[1]),
        .slow_osc_clock_i(src[2]), .device_ready_low_i(src[3]),
        .crystal_settled_flag_i(src[4]), .pin0_input_turnaround_low_i(turn_low),
        .general_output_pin_o(pin), .general_output_pin_oe_o(oe));
    pin_sink #(.PINS(3)) sink (.ref_clk_i(ref_clk_i), .pin_i(pin), .oe_i(oe), .wire_o(seen));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        // Hold the request until ack is seen; only the watchdog ends a hung wait
        do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic count_high(input int p, input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge ref_clk_i);
            c += (seen[p] === 1'b1);
        end
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        int c;
        wait_clk(2);
        chk("oe", 32'h1, {29'h0, oe});
        // The first high phase after reset is one cycle longer while the divider restarts
        wait_clk(1);
        count_high(0, 384, c);
        chk("div192 high", 32'd192, c);
        wb(1'b0, CFG0_OFS, 32'h0);
        chk("cfg0", 32'h3f, rd);
        wb(1'b0, CFG1_OFS, 32'h0);
        chk("cfg1", 32'h2e, rd);
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, rd);
        wb(1'b0, STATUS_OFS, 32'h0);
        chk("status", 32'h108, rd & 32'hffff_fff8);
    endtask

    task automatic t_status;
        logic [5:0] code [5] = '{6'h24, 6'h25, 6'h27, 6'h29, 6'h2b};
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, CFG1_OFS, {26'h0, code[i]});
            src <= 5'h01 << i;
            wait_clk(3);
            chk("status high", 32'h1, seen[1]);
            src <= ~(5'h01 << i);
            wait_clk(3);
            chk("status low", 32'h0, seen[1]);
        end
        wb(1'b1, CFG2_OFS, {26'h0, SEL_TURN_LOW});
        turn_low <= 1'b0;
        wait_clk(3);
        chk("turn pin2", 32'h0, seen[2]);
        chk("turn oe0", 32'h0, oe[0]);
        turn_low <= 1'b1;
        wait_clk(3);
        chk("turn pin2", 32'h1, seen[2]);
        chk("turn oe0", 32'h1, oe[0]);
    endtask

    task automatic t_reserved;
        logic [5:0] code [8] = '{6'h1e, 6'h20, 6'h23, 6'h26, 6'h28, 6'h2a, 6'h2c, 6'h2f};
        src <= 5'h1f;
        for (int v = 0; v < 2; v++) begin
            for (int i = 0; i < 8; i++) begin
                wb(1'b1, CFG2_OFS, {25'h0, v[0], code[i]});
                wait_clk(3);
                chk("fixed level", v, seen[2]);
            end
        end
        wb(1'b1, CFG2_OFS, {26'h0, SEL_HIGH_Z});
        wait_clk(3);
        chk("oe2", 32'h0, oe[2]);
    endtask

    task automatic t_divider;
        int c;
        wb(1'b1, CFG0_OFS, {26'h0, SEL_CONST});
        wb(1'b1, CFG1_OFS, 32'h31);
        // Two pins ask for the divider on purpose, to see the lower pin win
        wb(1'b1, CFG2_OFS, 32'h30);
        wait_clk(10);
        count_high(1, 30, c);
        chk("div1.5 high", 32'd10, c);
        count_high(2, 30, c);
        chk("loser pin", 32'd0, c);
        wb(1'b1, CFG1_OFS, {26'h0, SEL_CONST});
        wait_clk(10);
        count_high(2, 30, c);
        chk("div1 high", 32'd15, c);
        wb(1'b0, STATUS_OFS, 32'h0);
        chk("status", 32'h438, rd & 32'hffff_fff8);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        wait_clk(2);
        rstn_i <= 1'b1;
        t_reset();
        t_status();
        t_reserved();
        t_divider();
        complete_run();
    end

    initial begin
        #200000;
        err_count++;
        complete_run();
    end
endmodule
